// file: inc/bst_pkg.sv
package bst_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int N_IO = 4;
    localparam int BSR_W = 2 * N_IO;
    localparam int LINK_W = 3;

    // ****************************************
    // instruction codes and fixed values
    // ****************************************
    localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] OP_SAMPLE = 3'h2;
    localparam logic [IR_W-1:0] OP_CLAMP = 3'h3;
    localparam logic [IR_W-1:0] OP_HIGHZ = 3'h4;
    localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
    localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;
    localparam logic BYP_CAPTURE = 1'h0;
    // identification value is arbitrary, bit 0 kept at one
    localparam logic [ID_W-1:0] ID_CODE_DEF = 32'h0A5C_3E01;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        TAP_TLR = 4'h0,
        TAP_RTI = 4'h1,
        TAP_SDS = 4'h2,
        TAP_CDR = 4'h3,
        TAP_SDR = 4'h4,
        TAP_E1D = 4'h5,
        TAP_PDR = 4'h6,
        TAP_E2D = 4'h7,
        TAP_UDR = 4'h8,
        TAP_SIS = 4'h9,
        TAP_CIR = 4'hA,
        TAP_SIR = 4'hB,
        TAP_E1I = 4'hC,
        TAP_PIR = 4'hD,
        TAP_E2I = 4'hE,
        TAP_UIR = 4'hF
    } bst_state_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bst_link_s;

    typedef struct packed {
        logic [N_IO-1:0] out;
        logic [N_IO-1:0] oe_n;
    } bst_pad_s;

endpackage : bst_pkg

// file: hdl/bst_sync.sv
`timescale 1ns/1ns
module bst_sync
    import bst_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;
    wire logic [W-1:0] differ;

    // a bit only moves once the second and third stage agree
    assign differ = s2_reg ^ s3_reg;
    assign q_next = (s3_reg & ~differ) | (q_reg & differ);
    assign q = q_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end
        else
        begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

endmodule : bst_sync

// file: hdl/bst_buf2.sv
`timescale 1ns/1ns
module bst_buf2
    import bst_pkg::*;
#(
    parameter int W = 8
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    logic [W-1:0] mem_reg [2];
    logic wr_reg;
    logic rd_reg;
    logic [1:0] cnt_reg;
    wire logic push;
    wire logic pop;

    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_reg[rd_reg];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wr_reg <= 1'h0;
            rd_reg <= 1'h0;
            cnt_reg <= 2'h0;
        end
        else
        begin
            if (push)
                mem_reg[wr_reg] <= in_data;
            wr_reg <= wr_reg ^ push;
            rd_reg <= rd_reg ^ pop;
            cnt_reg <= cnt_reg + {1'h0, push} - {1'h0, pop};
        end
    end

endmodule : bst_buf2

// file: hdl/bst_tap.sv
`timescale 1ns/1ns
module bst_tap
    import bst_pkg::*;
#(
    parameter logic [ID_W-1:0] ID_CODE = ID_CODE_DEF
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic test_clock_pin,
    input wire logic test_reset_pin_n,
    input wire logic test_mode_select,
    input wire logic test_serial_in,
    output logic test_serial_out,
    output logic test_serial_out_oe_n,
    input wire logic [N_IO-1:0] core_out,
    input wire logic [N_IO-1:0] pad_in,
    output logic [N_IO-1:0] pad_out,
    output logic [N_IO-1:0] pad_oe_n,
    output logic upd_valid,
    input wire logic upd_ready,
    output logic [BSR_W-1:0] upd_data,
    output logic upd_room
);

    // ****************************************
    // reset and pin sampling
    // ****************************************
    logic rst1_reg;
    logic rst_n_reg;
    wire logic tap_rst_n;
    bst_link_s link_in;
    bst_link_s link_f;
    logic [N_IO-1:0] pad_in_f;
    logic tck_prev_reg;
    wire logic rise;
    wire logic fall;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst1_reg <= 1'h0;
            rst_n_reg <= 1'h0;
        end
        else
        begin
            rst1_reg <= 1'h1;
            rst_n_reg <= rst1_reg;
        end
    end

    // test reset acts without the clock, so it joins the async reset
    assign tap_rst_n = rst_n_reg & test_reset_pin_n;

    assign link_in.tck = test_clock_pin;
    assign link_in.tms = test_mode_select;
    assign link_in.tdi = test_serial_in;

    bst_sync #(.W(LINK_W)) u_link_sync (
        .clk(clk),
        .rst_n(rst_n_reg),
        .d(link_in),
        .q(link_f)
    );

    bst_sync #(.W(N_IO)) u_pad_sync (
        .clk(clk),
        .rst_n(rst_n_reg),
        .d(pad_in),
        .q(pad_in_f)
    );

    // tms and tdi share the tck delay, so they line up with its edges
    assign rise = link_f.tck & ~tck_prev_reg;
    assign fall = ~link_f.tck & tck_prev_reg;

    // ****************************************
    // controller
    // ****************************************
    function automatic bst_state_e tap_next(bst_state_e s, logic tms);
        bst_state_e n;
        n = TAP_TLR;
        case (s)
            TAP_TLR: n = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: n = tms ? TAP_SDS : TAP_RTI;
            TAP_SDS: n = tms ? TAP_SIS : TAP_CDR;
            TAP_CDR: n = tms ? TAP_E1D : TAP_SDR;
            TAP_SDR: n = tms ? TAP_E1D : TAP_SDR;
            TAP_E1D: n = tms ? TAP_UDR : TAP_PDR;
            TAP_PDR: n = tms ? TAP_E2D : TAP_PDR;
            TAP_E2D: n = tms ? TAP_UDR : TAP_SDR;
            TAP_UDR: n = tms ? TAP_SDS : TAP_RTI;
            TAP_SIS: n = tms ? TAP_TLR : TAP_CIR;
            TAP_CIR: n = tms ? TAP_E1I : TAP_SIR;
            TAP_SIR: n = tms ? TAP_E1I : TAP_SIR;
            TAP_E1I: n = tms ? TAP_UIR : TAP_PIR;
            TAP_PIR: n = tms ? TAP_E2I : TAP_PIR;
            TAP_E2I: n = tms ? TAP_UIR : TAP_SIR;
            TAP_UIR: n = tms ? TAP_SDS : TAP_RTI;
            default: n = TAP_TLR;
        endcase
        return n;
    endfunction : tap_next

    bst_state_e state_reg;
    wire bst_state_e state_next;

    assign state_next = rise ? tap_next(state_reg, link_f.tms) : state_reg;

    // ****************************************
    // instruction and data registers
    // ****************************************
    logic [IR_W-1:0] ir_sr_reg;
    logic [IR_W-1:0] ir_reg;
    logic [ID_W-1:0] id_sr_reg;
    logic [BSR_W-1:0] bsr_sr_reg;
    logic [BSR_W-1:0] bsr_upd_reg;
    logic byp_reg;
    logic tdo_reg;
    logic tdo_oe_n_reg;
    bst_pad_s pad_reg;
    bst_pad_s pad_next;

    wire logic sel_bsr = (ir_reg == OP_EXTEST) || (ir_reg == OP_SAMPLE);
    wire logic sel_id = (ir_reg == OP_IDCODE);
    // codes without a register of their own fall back to bypass
    wire logic sel_byp = ~sel_bsr & ~sel_id;
    wire logic drive_bsr = (ir_reg == OP_EXTEST) || (ir_reg == OP_CLAMP);
    wire logic float_all = (ir_reg == OP_HIGHZ);

    wire logic cap_dr = rise && (state_reg == TAP_CDR);
    wire logic sh_dr = rise && (state_reg == TAP_SDR);
    wire logic cap_ir = rise && (state_reg == TAP_CIR);
    wire logic sh_ir = rise && (state_reg == TAP_SIR);
    wire logic upd_dr = fall && (state_reg == TAP_UDR);
    wire logic upd_ir = fall && (state_reg == TAP_UIR);
    wire logic in_shift = (state_reg == TAP_SDR) || (state_reg == TAP_SIR);

    wire logic [IR_W-1:0] ir_sr_next =
        cap_ir ? IR_CAPTURE :
        sh_ir ? {link_f.tdi, ir_sr_reg[IR_W-1:1]} : ir_sr_reg;
    wire logic [IR_W-1:0] ir_next =
        (state_reg == TAP_TLR) ? IR_RESET :
        upd_ir ? ir_sr_reg : ir_reg;
    wire logic [ID_W-1:0] id_next =
        (cap_dr && sel_id) ? ID_CODE :
        (sh_dr && sel_id) ? {link_f.tdi, id_sr_reg[ID_W-1:1]} : id_sr_reg;
    // both cells groups sample their own pins; no effect on the core
    wire logic [BSR_W-1:0] bsr_next =
        (cap_dr && sel_bsr) ? {pad_in_f, core_out} :
        (sh_dr && sel_bsr) ? {link_f.tdi, bsr_sr_reg[BSR_W-1:1]} : bsr_sr_reg;
    wire logic [BSR_W-1:0] bsr_upd_next = (upd_dr && sel_bsr) ? bsr_sr_reg : bsr_upd_reg;
    wire logic byp_next =
        (cap_dr && sel_byp) ? BYP_CAPTURE :
        (sh_dr && sel_byp) ? link_f.tdi : byp_reg;
    wire logic dr_bit = sel_bsr ? bsr_sr_reg[0] : (sel_id ? id_sr_reg[0] : byp_reg);
    wire logic tdo_next = fall ? ((state_reg == TAP_SIR) ? ir_sr_reg[0] : dr_bit) : tdo_reg;
    wire logic tdo_oe_n_next = fall ? ~in_shift : tdo_oe_n_reg;

    assign pad_next.out = drive_bsr ? bsr_upd_reg[N_IO-1:0] : core_out;
    assign pad_next.oe_n = {N_IO{float_all}};

    always_ff @(posedge clk or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            tck_prev_reg <= 1'h0;
            state_reg <= TAP_TLR;
            ir_sr_reg <= IR_RESET;
            ir_reg <= IR_RESET;
            id_sr_reg <= '0;
            bsr_sr_reg <= '0;
            bsr_upd_reg <= '0;
            byp_reg <= 1'h0;
            tdo_reg <= 1'h0;
            tdo_oe_n_reg <= 1'h1;
            pad_reg <= '0;
        end
        else
        begin
            tck_prev_reg <= link_f.tck;
            state_reg <= state_next;
            ir_sr_reg <= ir_sr_next;
            ir_reg <= ir_next;
            id_sr_reg <= id_next;
            bsr_sr_reg <= bsr_next;
            bsr_upd_reg <= bsr_upd_next;
            byp_reg <= byp_next;
            tdo_reg <= tdo_next;
            tdo_oe_n_reg <= tdo_oe_n_next;
            pad_reg <= pad_next;
        end
    end

    assign test_serial_out = tdo_reg;
    assign test_serial_out_oe_n = tdo_oe_n_reg;
    assign pad_out = pad_reg.out;
    assign pad_oe_n = pad_reg.oe_n;

    // ****************************************
    // update word stream
    // ****************************************
    // a word offered while both entries are full is dropped; upd_room warns
    bst_buf2 #(.W(BSR_W)) u_upd_buf (
        .clk(clk),
        .rst_n(rst_n_reg),
        .in_valid(upd_dr && sel_bsr),
        .in_ready(upd_room),
        .in_data(bsr_sr_reg),
        .out_valid(upd_valid),
        .out_ready(upd_ready),
        .out_data(upd_data)
    );

    // ****************************************
    // checks
    // ****************************************
    state_hold_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        !rise |=> $stable(state_reg)) else $error("state moved without tck rise");
    reset_ident_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        state_reg == TAP_TLR |=> ir_reg == OP_IDCODE) else $error("reset lost idcode");
    select_dr_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        rise && state_reg == TAP_SDS |=> state_reg == ($past(link_f.tms) ? TAP_SIS : TAP_CDR))
        else $error("bad select-dr step");
    exit1_dr_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        rise && state_reg == TAP_E1D |=> state_reg == ($past(link_f.tms) ? TAP_UDR : TAP_PDR))
        else $error("bad exit1-dr step");
    pause_dr_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        rise && state_reg == TAP_PDR && !link_f.tms |=> state_reg == TAP_PDR)
        else $error("pause-dr left on low");
    exit2_dr_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        rise && state_reg == TAP_E2D |=> state_reg == ($past(link_f.tms) ? TAP_UDR : TAP_SDR))
        else $error("bad exit2-dr step");
    update_dr_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        upd_dr && sel_bsr |=> bsr_upd_reg == $past(bsr_sr_reg))
        else $error("update latch missed");
    buf_push_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        upd_dr && sel_bsr && upd_room |=> upd_valid) else $error("update word lost");
    sel_ir_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        rise && state_reg == TAP_SIS |=> state_reg == ($past(link_f.tms) ? TAP_TLR : TAP_CIR))
        else $error("bad select-ir step");
    cap_ir_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        cap_ir |=> ir_sr_reg == IR_CAPTURE) else $error("capture-ir value wrong");
    ir_shift_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        sh_ir |=> ir_sr_reg[IR_W-1] == $past(link_f.tdi)) else $error("ir shift wrong");
    exit2_ir_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        rise && state_reg == TAP_E2I |=> state_reg == ($past(link_f.tms) ? TAP_UIR : TAP_SIR))
        else $error("bad exit2-ir step");
    upd_ir_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        upd_ir |=> ir_reg == $past(ir_sr_reg)) else $error("instruction not latched");
    dr_shift_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        sh_dr && sel_bsr |=> bsr_sr_reg[BSR_W-1] == $past(link_f.tdi))
        else $error("boundary shift wrong");
    bypass_decode_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        (ir_reg == OP_CLAMP || ir_reg == OP_HIGHZ || ir_reg == OP_BYPASS) |-> sel_byp)
        else $error("bypass not selected");
    cap_id_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        cap_dr && sel_id |=> id_sr_reg == ID_CODE) else $error("id code not loaded");
    byp_shift_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        sh_dr && sel_byp |=> byp_reg == $past(link_f.tdi)) else $error("bypass shift wrong");
    normal_pads_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        !drive_bsr ##1 !drive_bsr |=> pad_out == $past(core_out))
        else $error("pads not following core");
    highz_pads_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        float_all ##1 float_all |-> pad_oe_n == {N_IO{1'h1}}) else $error("highz pad driven");
    clamp_hold_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        (ir_reg == OP_CLAMP) [*2] |-> $stable(bsr_upd_reg)) else $error("clamp data moved");
    tdo_float_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        fall && !in_shift |=> test_serial_out_oe_n) else $error("tdo driven outside shift");
    tdo_drive_a: assert property (@(posedge clk) disable iff (!tap_rst_n)
        fall && in_shift |=> !test_serial_out_oe_n) else $error("tdo idle in shift");
    // test reset disables the checks above, so this one keys on the arst copy only
    trst_tlr_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
        !test_reset_pin_n |-> state_reg == TAP_TLR) else $error("test reset ignored");

    ir_update_c: cover property (@(posedge clk) disable iff (!tap_rst_n) upd_ir);
    pause_ir_c: cover property (@(posedge clk) disable iff (!tap_rst_n) rise && state_reg == TAP_PIR);
    id_capture_c: cover property (@(posedge clk) disable iff (!tap_rst_n) cap_dr && sel_id);
    extest_drive_c: cover property (@(posedge clk) disable iff (!tap_rst_n)
        upd_dr && ir_reg == OP_EXTEST);
    buf_full_c: cover property (@(posedge clk) disable iff (!tap_rst_n) !upd_room);

endmodule : bst_tap

// file: tb/bst_tester.sv
`timescale 1ns/1ns
// ****************************************
// tester on the far side of the link
// ****************************************
module bst_tester
    import bst_pkg::*;
(
    input wire logic clk,
    input wire logic tdo_line,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end

    // one 160 ns period; clock parked low between calls
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        @(posedge clk);
        tck <= 1'b1;
        repeat (4) @(posedge clk);
        // tdo trails the fall by ~5 clk, so read late in the high phase
        o = tdo_line;
        tck <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : step

    task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = 32'h0;
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
    endtask : scan

    task automatic pulse_reset();
        @(posedge clk);
        trst_n <= 1'b0;
        repeat (3) @(posedge clk);
        trst_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : pulse_reset
endmodule : bst_tester

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
    import bst_pkg::*;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic tdo;
    logic tdo_oe_n;
    wire logic tdo_line;
    logic [N_IO-1:0] core_out = 4'h0;
    logic [N_IO-1:0] pad_in = 4'h0;
    logic [N_IO-1:0] pad_out;
    logic [N_IO-1:0] pad_oe_n;
    logic upd_valid;
    logic upd_ready = 1'b0;
    logic upd_room;
    logic [BSR_W-1:0] upd_data;
    int num_errors = 0;
    int n_tests = 0;
    logic [31:0] d;
    logic [31:0] c;

    always #10 clk = ~clk;
    // a released serial line floats, so a stray read never matches
    assign tdo_line = tdo_oe_n ? 1'bz : tdo;

    bst_tester tst (.clk(clk), .tdo_line(tdo_line), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n));

    bst_tap dut (.clk(clk), .arst_n(arst_n), .test_clock_pin(tck), .test_reset_pin_n(trst_n),
        .test_mode_select(tms), .test_serial_in(tdi), .test_serial_out(tdo),
        .test_serial_out_oe_n(tdo_oe_n), .core_out(core_out), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .upd_valid(upd_valid),
        .upd_ready(upd_ready), .upd_data(upd_data), .upd_room(upd_room));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // tms bits lsb first
    task automatic walk(input logic [7:0] seq, input int n);
        logic o;
        for (int i = 0; i < n; i++)
            tst.step(seq[i], 1'b0, o);
    endtask : walk

    task automatic ir(input logic [2:0] code, input logic p);
        walk(8'h03, 4);
        tst.scan(3, {29'h0, code}, c);
        if (p)
            walk(8'h02, 2);
        walk(8'h01, 2);
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask : ir

    task automatic dr(input int n, input logic [31:0] din);
        walk(8'h01, 3);
        tst.scan(n, din, d);
        walk(8'h01, 2);
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask : dr

    task automatic pop();
        @(posedge clk);
        upd_ready <= 1'b1;
        @(posedge clk);
        upd_ready <= 1'b0;
        @(negedge clk);
    endtask : pop

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_id();
        dr(32, 32'h0);
        check(d, ID_CODE_DEF);
        check(tdo_oe_n, 1'b1);
        $display("test id done");
    endtask : t_id

    task automatic t_pause();
        logic [31:0] lo;
        ir(OP_IDCODE, 1'b1);
        check(c, {29'h0, IR_CAPTURE});
        walk(8'h01, 3);
        tst.scan(16, 32'h0, lo);
        walk(8'h04, 4);
        tst.scan(16, 32'h0, d);
        walk(8'h01, 2);
        check({d[15:0], lo[15:0]}, ID_CODE_DEF);
        $display("test pause done");
    endtask : t_pause

    task automatic t_byp();
        logic [2:0] codes [5] = '{OP_BYPASS, OP_CLAMP, OP_HIGHZ, 3'h5, 3'h6};
        foreach (codes[i])
        begin
            ir(codes[i], i == 0);
            dr(8, 32'hA5);
            check(d, 32'h4A);
        end
        ir(OP_BYPASS, 1'b0);
        check({pad_oe_n, pad_out}, {4'h0, core_out});
        $display("test bypass done");
    endtask : t_byp

    task automatic t_sample();
        @(posedge clk);
        core_out <= 4'h6;
        pad_in <= 4'h9;
        ir(OP_SAMPLE, 1'b0);
        dr(8, 32'h3C);
        check(d, 32'h96);
        check({upd_valid, upd_data}, 9'h13C);
        pop();
        ir(OP_EXTEST, 1'b0);
        check({pad_oe_n, pad_out}, 8'h0C);
        ir(OP_CLAMP, 1'b0);
        @(posedge clk);
        core_out <= 4'h1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check({pad_oe_n, pad_out}, 8'h0C);
        ir(OP_HIGHZ, 1'b0);
        check(pad_oe_n, 4'hF);
        $display("test sample done");
    endtask : t_sample

    // receiver stalls; third word must be dropped, not overwrite
    task automatic t_buf();
        ir(OP_SAMPLE, 1'b0);
        dr(8, 32'h11);
        dr(8, 32'h22);
        check(upd_room, 1'b0);
        dr(8, 32'h33);
        check({upd_valid, upd_data}, 9'h111);
        pop();
        check({upd_valid, upd_data}, 9'h122);
        pop();
        check({upd_valid, upd_room}, 2'h1);
        $display("test buffer done");
    endtask : t_buf

    task automatic t_reset();
        ir(OP_BYPASS, 1'b0);
        walk(8'h07, 4);
        dr(32, 32'h0);
        check(d, ID_CODE_DEF);
        ir(OP_BYPASS, 1'b0);
        tst.pulse_reset();
        walk(8'h00, 1);
        dr(32, 32'h0);
        check(d, ID_CODE_DEF);
        $display("test reset done");
    endtask : t_reset

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (10) @(posedge clk);
        walk(8'h00, 1);
        t_id();
        t_pause();
        t_byp();
        t_sample();
        t_buf();
        t_reset();
        finish_test();
    end

    initial
    begin
        #400000;
        num_errors++;
        finish_test();
    end
endmodule : tb
